// *** rtl/cie_core.sv ***
// Instruction executor: fetches, decodes and runs one instruction stream.
// Assumes program memory answers prog_addr on prog_data in the same cycle,
// and data and I/O space answer a registered address in the next cycle.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Add with carry: sum, five flags, one cycle
// - Word add immediate to pair, two cycles
// - Word subtract immediate from pair, two cycles
// - Register subtract with carry, five flags, one cycle
// - Constant subtract with carry, five flags, one cycle
// - AND/OR/XOR set only Z, N, V
// - Complement is FF minus value, sets carry
// - Set bits ORs immediate mask
// - Clear bits ANDs with FF minus mask
// - Test ANDs register with itself
// - Compare immediate updates flags, stores nothing
// - Skip next when two registers equal
// - Skip on register bit clear or set
// - Skip on I/O bit clear or set
// - Taken branch loads PC plus offset plus one
// - Signed branches test N xor V
// - Unsigned branches test carry
// - Interrupt branches test global enable
// - Indirect jump loads Z, two cycles
// - Indirect call loads Z, three cycles
// - Post-increment load through X
// - Pre-decrement load through X
module cie_core (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [15:0] prog_data,
	input  wire logic [7:0]  dmem_rdata,
	input  wire logic [7:0]  io_rdata,
	input  wire logic        irq_enable,
	output logic      [15:0] prog_addr,
	output logic      [15:0] dmem_addr,
	output logic             dmem_re,
	output logic             dmem_we,
	output logic      [7:0]  dmem_wdata,
	output logic      [4:0]  io_addr,
	output logic             io_re,
	output logic      [7:0]  status_flags
);
	// --------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------
	logic               rst_meta;
	logic               rst_n;
	cie_pkg::cie_state_e state;
	cie_pkg::cie_alu_e  alu_op;
	logic [15:0]        held;
	logic [15:0]        ir;
	logic [15:0]        sp;
	logic [15:0]        ret_pc;
	logic [15:0]        pair_rd;
	logic [15:0]        wres;
	logic [15:0]        pair_wdata;
	logic [15:0]        br_target;
	logic [7:0]         rd_a;
	logic [7:0]         rd_b;
	logic [7:0]         alu_b;
	logic [7:0]         alu_res;
	logic [7:0]         rf_w_data;
	logic [7:0]         next_status_flag_register;
	logic [4:0]         ra_idx;
	logic [4:0]         rf_w_idx;
	logic [1:0]         pair_sel;
	logic               alu_h, alu_v, alu_n, alu_z, alu_c, alu_cin;
	logic               rf_we, pair_we, alu_wr, ex;
	logic               is_add, is_adc, is_sub, is_sbc, is_cp, is_cpc, is_compare_skip_equal;
	logic               is_and, is_eor, is_or, is_mov, is_cpi, is_carry_subtract_constant, is_subi;
	logic               is_ori, is_andi, is_imm, is_com, is_word_immediate_add, is_word_immediate_subtract, is_ldi;
	logic               is_ijmp, is_icall, is_ldx, is_sbrx, is_sbix, is_brx;
	logic               grp_sub, grp_logic, br_flag, br_taken, skip_now, io_hit;

	function automatic logic two_word(input logic [15:0] w);
		two_word = ((w & 16'hFC0F) == 16'h9000) || ((w & 16'hFE0C) == 16'h940C);
	endfunction: two_word

	// --------------------------------------------------------------
	// Reset release
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// --------------------------------------------------------------
	// Decode
	// --------------------------------------------------------------
	// Multi-cycle states work from the word held at issue
	assign ex       = (state == cie_pkg::ST_EXEC);
	assign ir       = ex ? prog_data : held;
	assign is_cpc   = ir[15:10] == 6'h01;
	assign is_sbc   = ir[15:10] == 6'h02;
	assign is_add   = ir[15:10] == 6'h03;
	assign is_compare_skip_equal  = ir[15:10] == 6'h04;
	assign is_cp    = ir[15:10] == 6'h05;
	assign is_sub   = ir[15:10] == 6'h06;
	assign is_adc   = ir[15:10] == 6'h07;
	assign is_and   = ir[15:10] == 6'h08;
	assign is_eor   = ir[15:10] == 6'h09;
	assign is_or    = ir[15:10] == 6'h0A;
	assign is_mov   = ir[15:10] == 6'h0B;
	assign is_cpi   = ir[15:12] == 4'h3;
	assign is_carry_subtract_constant  = ir[15:12] == 4'h4;
	assign is_subi  = ir[15:12] == 4'h5;
	assign is_ori   = ir[15:12] == 4'h6;
	assign is_andi  = ir[15:12] == 4'h7;
	// Load immediate passes the constant straight through, flags untouched
	assign is_ldi   = ir[15:12] == 4'hE;
	assign is_imm   = is_cpi | is_carry_subtract_constant | is_subi | is_ori | is_andi | is_ldi;
	assign is_com   = (ir & 16'hFE0F) == 16'h9400;
	assign is_word_immediate_add  = ir[15:8] == 8'h96;
	assign is_word_immediate_subtract  = ir[15:8] == 8'h97;
	assign is_ijmp  = ir == 16'h9409;
	assign is_icall = ir == 16'h9509;
	assign is_ldx   = ((ir & 16'hFE0C) == 16'h900C) && (ir[1:0] != 2'b11);
	assign is_sbrx  = (ir[15:10] == 6'h3F) && !ir[3];
	assign is_sbix  = (ir[15:10] == 6'h26) && ir[8];
	assign is_brx   = ir[15:11] == 5'h1E;
	assign grp_sub  = is_sub | is_sbc | is_cp | is_cpc | is_cpi | is_subi | is_carry_subtract_constant;
	// Set bits and clear bits arrive as OR and AND with an immediate
	assign grp_logic = is_and | is_or | is_eor | is_ori | is_andi;
	// Compares write flags only
	assign alu_wr   = ex & (is_add | is_adc | (grp_sub & ~(is_cp | is_cpc | is_cpi))
	                  | grp_logic | is_com | is_mov | is_ldi);

	// --------------------------------------------------------------
	// Operand selection
	// --------------------------------------------------------------
	always_comb begin
		ra_idx   = is_imm ? {1'b1, ir[7:4]} : ir[8:4];
		alu_b    = is_imm ? {ir[11:8], ir[3:0]} : rd_b;
		alu_cin  = 1'b0;
		alu_op   = cie_pkg::ALU_PASS;
		pair_sel = (is_word_immediate_add | is_word_immediate_subtract) ? ir[5:4] : (is_ldx ? cie_pkg::PAIR_X : cie_pkg::PAIR_Z);
		if (is_add || is_adc) begin
			alu_op  = cie_pkg::ALU_ADD;
			alu_cin = is_adc & status_flags[cie_pkg::FLAG_C];
		end else if (grp_sub) begin
			alu_op  = cie_pkg::ALU_SUB;
			alu_cin = (is_sbc | is_cpc | is_carry_subtract_constant) & status_flags[cie_pkg::FLAG_C];
		end else if (is_and || is_andi) begin
			alu_op  = cie_pkg::ALU_AND;
		end else if (is_or || is_ori) begin
			alu_op  = cie_pkg::ALU_OR;
		end else if (is_eor) begin
			alu_op  = cie_pkg::ALU_XOR;
		end else if (is_com) begin
			alu_op  = cie_pkg::ALU_COM;
		end
	end

	// Whole pair result, written in the second cycle
	assign wres = is_word_immediate_subtract ? pair_rd - {10'h000, ir[7:6], ir[3:0]}
	                      : pair_rd + {10'h000, ir[7:6], ir[3:0]};

	// --------------------------------------------------------------
	// Register file write
	// --------------------------------------------------------------
	always_comb begin
		rf_we      = 1'b0;
		rf_w_idx   = ra_idx;
		rf_w_data  = alu_res;
		pair_we    = 1'b0;
		pair_wdata = wres;
		case (state)
			cie_pkg::ST_EXEC: begin
				rf_we = alu_wr;
			end
			cie_pkg::ST_WORD: begin
				pair_we = 1'b1;
			end
			cie_pkg::ST_LOAD: begin
				rf_we      = 1'b1;
				rf_w_idx   = ir[8:4];
				rf_w_data  = dmem_rdata;
				pair_we    = ir[1:0] != 2'b00;
				// Address already holds X-1 for pre-decrement
				pair_wdata = ir[0] ? dmem_addr + 16'h0001 : dmem_addr;
			end
			default: begin
				rf_we = 1'b0;
			end
		endcase
	end

	// --------------------------------------------------------------
	// Status flags
	// --------------------------------------------------------------
	always_comb begin
		next_status_flag_register = status_flags;
		next_status_flag_register[cie_pkg::FLAG_I] = irq_enable;
		if (ex && (is_add || is_adc || grp_sub)) begin
			next_status_flag_register[cie_pkg::FLAG_Z] = alu_z;
			next_status_flag_register[cie_pkg::FLAG_C] = alu_c;
			next_status_flag_register[cie_pkg::FLAG_N] = alu_n;
			next_status_flag_register[cie_pkg::FLAG_V] = alu_v;
			next_status_flag_register[cie_pkg::FLAG_H] = alu_h;
		end else if (ex && (grp_logic || is_com)) begin
			next_status_flag_register[cie_pkg::FLAG_Z] = alu_z;
			next_status_flag_register[cie_pkg::FLAG_N] = alu_n;
			next_status_flag_register[cie_pkg::FLAG_V] = 1'b0;
			if (is_com) begin
				next_status_flag_register[cie_pkg::FLAG_C] = alu_c;
			end
		end else if (state == cie_pkg::ST_WORD) begin
			next_status_flag_register[cie_pkg::FLAG_Z] = (wres == 16'h0000);
			next_status_flag_register[cie_pkg::FLAG_N] = wres[15];
			next_status_flag_register[cie_pkg::FLAG_V] = is_word_immediate_subtract ? (pair_rd[15] & ~wres[15])
			                                     : (~pair_rd[15] & wres[15]);
			next_status_flag_register[cie_pkg::FLAG_C] = is_word_immediate_subtract ? (wres[15] & ~pair_rd[15])
			                                     : (~wres[15] & pair_rd[15]);
		end
		next_status_flag_register[cie_pkg::FLAG_S] = next_status_flag_register[cie_pkg::FLAG_N] ^ next_status_flag_register[cie_pkg::FLAG_V];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_flags <= cie_pkg::STATUS_FLAG_REGISTER_RESET;
		end else begin
			status_flags <= next_status_flag_register;
		end
	end

	// --------------------------------------------------------------
	// Branch and skip conditions
	// --------------------------------------------------------------
	// S is formed live so signed branches never see a stale copy
	assign br_flag   = (ir[2:0] == 3'(cie_pkg::FLAG_S))
	                   ? (status_flags[cie_pkg::FLAG_N] ^ status_flags[cie_pkg::FLAG_V])
	                   : status_flags[ir[2:0]];
	assign br_taken  = is_brx && (br_flag != ir[10]);
	assign br_target = prog_addr + {{9{ir[9]}}, ir[9:3]} + 16'h0001;
	assign skip_now  = (is_compare_skip_equal && (rd_a == rd_b))
	                   || (is_sbrx && (rd_a[ir[2:0]] == ir[9]));
	assign io_hit    = io_rdata[ir[2:0]] == ir[9];

	// --------------------------------------------------------------
	// Sequencer and program counter
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= cie_pkg::ST_EXEC;
			prog_addr <= cie_pkg::PC_RESET;
			held      <= 16'h0000;
			ret_pc    <= 16'h0000;
		end else begin
			case (state)
				cie_pkg::ST_EXEC: begin
					held   <= prog_data;
					ret_pc <= prog_addr + 16'h0001;
					if (br_taken) begin
						prog_addr <= br_target;
						state     <= cie_pkg::ST_PAD;
					end else if (is_ijmp) begin
						prog_addr <= pair_rd;
						state     <= cie_pkg::ST_PAD;
					end else if (is_icall) begin
						prog_addr <= pair_rd;
						state     <= cie_pkg::ST_CALL;
					end else begin
						prog_addr <= prog_addr + 16'h0001;
						if (skip_now) begin
							state <= cie_pkg::ST_SKIP;
						end else if (is_word_immediate_add || is_word_immediate_subtract) begin
							state <= cie_pkg::ST_WORD;
						end else if (is_ldx) begin
							state <= cie_pkg::ST_LOAD;
						end else if (is_sbix) begin
							state <= cie_pkg::ST_IOTEST;
						end
					end
				end
				cie_pkg::ST_SKIP, cie_pkg::ST_IOTEST: begin
					// prog_data now shows the word being stepped over
					if (state == cie_pkg::ST_SKIP || io_hit) begin
						if (two_word(prog_data)) begin
							prog_addr <= prog_addr + 16'h0002;
							state     <= cie_pkg::ST_PAD;
						end else begin
							prog_addr <= prog_addr + 16'h0001;
							state     <= cie_pkg::ST_EXEC;
						end
					end else begin
						state <= cie_pkg::ST_EXEC;
					end
				end
				cie_pkg::ST_CALL: begin
					state <= cie_pkg::ST_PAD;
				end
				default: begin
					state <= cie_pkg::ST_EXEC;
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// Data, stack and I/O access
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dmem_addr  <= 16'h0000;
			dmem_re    <= 1'b0;
			dmem_we    <= 1'b0;
			dmem_wdata <= 8'h00;
			io_addr    <= 5'h00;
			io_re      <= 1'b0;
			sp         <= cie_pkg::SP_RESET;
		end else begin
			dmem_re <= 1'b0;
			dmem_we <= 1'b0;
			io_re   <= 1'b0;
			if (ex && is_ldx) begin
				dmem_addr <= ir[1] ? pair_rd - 16'h0001 : pair_rd;
				dmem_re   <= 1'b1;
			end else if (ex && is_icall) begin
				// Return address goes out low byte first
				dmem_addr  <= sp;
				dmem_wdata <= ret_pc_lo(prog_addr);
				dmem_we    <= 1'b1;
				sp         <= sp - 16'h0001;
			end else if (state == cie_pkg::ST_CALL) begin
				dmem_addr  <= sp;
				dmem_wdata <= ret_pc[15:8];
				dmem_we    <= 1'b1;
				sp         <= sp - 16'h0001;
			end else if (ex && is_sbix) begin
				io_addr <= ir[7:3];
				io_re   <= 1'b1;
			end
		end
	end

	function automatic logic [7:0] ret_pc_lo(input logic [15:0] pc);
		logic [15:0] nxt;
		nxt = pc + 16'h0001;
		ret_pc_lo = nxt[7:0];
	endfunction: ret_pc_lo

	// --------------------------------------------------------------
	// Datapath instances
	// --------------------------------------------------------------
	cie_alu u_alu (
		.a      (rd_a),
		.b      (alu_b),
		.cin    (alu_cin),
		.op     (alu_op),
		.res    (alu_res),
		.flag_h (alu_h),
		.flag_v (alu_v),
		.flag_n (alu_n),
		.flag_z (alu_z),
		.flag_c (alu_c)
	);

	cie_regs u_regs (
		.clk        (clk),
		.rst_n      (rst_n),
		.ra_idx     (ra_idx),
		.rb_idx     ({ir[9], ir[3:0]}),
		.pair_sel   (pair_sel),
		.we         (rf_we),
		.w_idx      (rf_w_idx),
		.w_data     (rf_w_data),
		.pair_we    (pair_we),
		.pair_wdata (pair_wdata),
		.rd_a       (rd_a),
		.rd_b       (rd_b),
		.pair_rd    (pair_rd)
	);

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_adc_one;
		ex && is_adc |-> rf_we && rf_w_data == 8'(rd_a + rd_b + {7'h00, alu_cin})
			##1 ex;
	endproperty
	a_adc_one: assert property (p_adc_one) else $error("adc result or length wrong");

	property p_word_add;
		ex && is_word_immediate_add |=> state == cie_pkg::ST_WORD && pair_we
			&& pair_wdata == pair_rd + {10'h000, held[7:6], held[3:0]} ##1 ex;
	endproperty
	a_word_add: assert property (p_word_add) else $error("word add wrong");

	property p_word_sub;
		ex && is_word_immediate_subtract |=> pair_we && pair_wdata == pair_rd - {10'h000, held[7:6], held[3:0]}
			##1 ex && status_flags[cie_pkg::FLAG_C] == $past(wres[15] & ~pair_rd[15]);
	endproperty
	a_word_sub: assert property (p_word_sub) else $error("word subtract wrong");

	property p_sbc_carry;
		ex && (is_sbc || is_carry_subtract_constant) |=> ex && status_flags[cie_pkg::FLAG_C] == $past(alu_c)
			&& status_flags[cie_pkg::FLAG_H] == $past(alu_h);
	endproperty
	a_sbc_carry: assert property (p_sbc_carry) else $error("borrow flags wrong");

	property p_logic_keep_c;
		ex && grp_logic |=> status_flags[cie_pkg::FLAG_C] == $past(status_flags[cie_pkg::FLAG_C])
			&& !status_flags[cie_pkg::FLAG_V];
	endproperty
	a_logic_keep_c: assert property (p_logic_keep_c) else $error("logic op hit C or V");

	property p_com_carry;
		ex && is_com |-> rf_w_data == ~rd_a ##1 status_flags[cie_pkg::FLAG_C];
	endproperty
	a_com_carry: assert property (p_com_carry) else $error("complement wrong");

	property p_cpi_nostore;
		ex && (is_cpi || is_cp || is_cpc) |-> !rf_we;
	endproperty
	a_cpi_nostore: assert property (p_cpi_nostore) else $error("compare stored");

	property p_branch;
		ex && br_taken |=> prog_addr == $past(br_target) && state == cie_pkg::ST_PAD ##1 ex;
	endproperty
	a_branch: assert property (p_branch) else $error("branch target or length wrong");

	property p_icall;
		ex && is_icall |=> prog_addr == $past(pair_rd) && state == cie_pkg::ST_CALL
			##1 state == cie_pkg::ST_PAD ##1 ex;
	endproperty
	a_icall: assert property (p_icall) else $error("indirect call wrong");

	property p_sign;
		status_flags[cie_pkg::FLAG_S] == (status_flags[cie_pkg::FLAG_N] ^ status_flags[cie_pkg::FLAG_V]);
	endproperty
	a_sign: assert property (p_sign) else $error("sign flag not N xor V");

	property p_skip_two;
		state == cie_pkg::ST_SKIP && two_word(prog_data) |=> prog_addr == $past(prog_addr) + 16'h0002
			##1 ex;
	endproperty
	a_skip_two: assert property (p_skip_two) else $error("two-word skip wrong");

	c_word_op: cover property (ex && is_word_immediate_add);
	c_skip_two: cover property (state == cie_pkg::ST_SKIP && two_word(prog_data));
	c_branch: cover property (ex && br_taken);
	c_load_pre: cover property (state == cie_pkg::ST_LOAD && !held[0] && held[1]);
endmodule: cie_core

`default_nettype wire

// *** rtl/cie_pkg.sv ***
// Shared constants and types of the instruction executor.
// Assumes nothing beyond a SystemVerilog compiler; no timescale here.
package cie_pkg;
	// --------------------------------------------------------------
	// Status flag bit positions
	// --------------------------------------------------------------
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// --------------------------------------------------------------
	// Reset values and pointer pairs
	// --------------------------------------------------------------
	localparam logic [15:0] PC_RESET   = 16'h0000;
	localparam logic [15:0] SP_RESET   = 16'h00DF;
	localparam logic [7:0]  STATUS_FLAG_REGISTER_RESET = 8'h00;
	localparam logic [7:0]  REG_RESET  = 8'h00;
	localparam logic [1:0]  PAIR_X     = 2'h1;
	localparam logic [1:0]  PAIR_Z     = 2'h3;

	// --------------------------------------------------------------
	// Sequencer states and ALU operations
	// --------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_EXEC   = 3'b000,
		ST_WORD   = 3'b001,
		ST_SKIP   = 3'b010,
		ST_PAD    = 3'b011,
		ST_CALL   = 3'b100,
		ST_LOAD   = 3'b101,
		ST_IOTEST = 3'b110
	} cie_state_e;

	typedef enum logic [2:0] {
		ALU_ADD  = 3'b000,
		ALU_SUB  = 3'b001,
		ALU_AND  = 3'b010,
		ALU_OR   = 3'b011,
		ALU_XOR  = 3'b100,
		ALU_COM  = 3'b101,
		ALU_PASS = 3'b110
	} cie_alu_e;
endpackage: cie_pkg

// *** rtl/cie_alu.sv ***
// Eight-bit arithmetic and logic unit with flag outputs.
// Assumes operands are stable for the whole cycle; purely combinational.
`timescale 1ns/1ns
`default_nettype none

module cie_alu (
	input  wire logic [7:0]       a,
	input  wire logic [7:0]       b,
	input  wire logic             cin,
	input  wire cie_pkg::cie_alu_e op,
	output logic      [7:0]       res,
	output logic                  flag_h,
	output logic                  flag_v,
	output logic                  flag_n,
	output logic                  flag_z,
	output logic                  flag_c
);
	logic [8:0] sum;

	always_comb begin
		case (op)
			cie_pkg::ALU_ADD: sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			cie_pkg::ALU_SUB: sum = {1'b0, a} - {1'b0, b} - {8'h00, cin};
			cie_pkg::ALU_AND: sum = {1'b0, a & b};
			cie_pkg::ALU_OR:  sum = {1'b0, a | b};
			cie_pkg::ALU_XOR: sum = {1'b0, a ^ b};
			cie_pkg::ALU_COM: sum = {1'b1, 8'hFF - a};
			default:          sum = {1'b0, b};
		endcase
		res    = sum[7:0];
		flag_c = sum[8];
		flag_n = sum[7];
		flag_z = (sum[7:0] == 8'h00);
		flag_h = 1'b0;
		flag_v = 1'b0;
		if (op == cie_pkg::ALU_ADD) begin
			flag_h = (a[3] & b[3]) | (b[3] & ~sum[3]) | (~sum[3] & a[3]);
			flag_v = (a[7] & b[7] & ~sum[7]) | (~a[7] & ~b[7] & sum[7]);
		end else if (op == cie_pkg::ALU_SUB) begin
			// Borrow out of bit 3
			flag_h = (~a[3] & b[3]) | (b[3] & sum[3]) | (sum[3] & ~a[3]);
			flag_v = (a[7] & ~b[7] & ~sum[7]) | (~a[7] & b[7] & sum[7]);
		end
	end
endmodule: cie_alu

`default_nettype wire

// *** rtl/cie_regs.sv ***
// Thirty-two entry working register file with a 16-bit pair port.
// Assumes a synchronised active-low reset; reads are combinational.
`timescale 1ns/1ns
`default_nettype none

module cie_regs (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [4:0]  ra_idx,
	input  wire logic [4:0]  rb_idx,
	input  wire logic [1:0]  pair_sel,
	input  wire logic        we,
	input  wire logic [4:0]  w_idx,
	input  wire logic [7:0]  w_data,
	input  wire logic        pair_we,
	input  wire logic [15:0] pair_wdata,
	output logic      [7:0]  rd_a,
	output logic      [7:0]  rd_b,
	output logic      [15:0] pair_rd
);
	logic [7:0] file [0:31];
	logic [4:0] p_lo;
	logic [4:0] p_hi;

	// Pairs live in the top eight entries, low byte at the even index
	assign p_lo    = {2'b11, pair_sel, 1'b0};
	assign p_hi    = {2'b11, pair_sel, 1'b1};
	assign rd_a    = file[ra_idx];
	assign rd_b    = file[rb_idx];
	assign pair_rd = {file[p_hi], file[p_lo]};

	// Byte write follows the pair write so it wins on overlap
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 32; i++) begin
				file[i] <= cie_pkg::REG_RESET;
			end
		end else begin
			if (pair_we) begin
				file[p_lo] <= pair_wdata[7:0];
				file[p_hi] <= pair_wdata[15:8];
			end
			if (we) begin
				file[w_idx] <= w_data;
			end
		end
	end
endmodule: cie_regs

`default_nettype wire

// *** testbench/cie_mem_model.sv ***
// Program, data and I/O memories on the far side of the executor.
// Assumes the bench fills pm, dm and io before reset is released.
`timescale 1ns/1ns
`default_nettype none
module cie_mem_model (
	input  wire logic        clk,
	input  wire logic [15:0] prog_addr,
	input  wire logic [15:0] dmem_addr,
	input  wire logic        dmem_re,
	input  wire logic        dmem_we,
	input  wire logic [7:0]  dmem_wdata,
	input  wire logic [4:0]  io_addr,
	input  wire logic        io_re,
	output logic      [15:0] prog_data,
	output logic      [7:0]  dmem_rdata,
	output logic      [7:0]  io_rdata
);
	logic [15:0] pm [256] = '{default: 16'h0000};
	logic [7:0]  dm [256] = '{default: 8'h00};
	logic [7:0]  io [32]  = '{default: 8'h00};
	// Unstrobed buses show inverted data so a stale value never passes
	assign prog_data  = pm[prog_addr[7:0]];
	assign dmem_rdata = dmem_re ? dm[dmem_addr[7:0]] : ~dm[dmem_addr[7:0]];
	assign io_rdata   = io_re ? io[io_addr] : ~io[io_addr];
	always @(posedge clk) begin
		if (dmem_we === 1'b1) begin
			dm[dmem_addr[7:0]] <= dmem_wdata;
		end
	end
endmodule: cie_mem_model
`default_nettype wire

// *** testbench/test_cpu_instruction_executor.sv ***
// Self-checking bench: one random program exercising the executor.
// Assumes the memory model answers program fetches combinationally.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
	$display("wrong value at %0t: %h, expected %h", $time, g, e); end end
module test_cpu_instruction_executor;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        irq_enable = 1'b0;
	logic [15:0] prog_data, prog_addr, dmem_addr;
	logic [7:0]  dmem_rdata, io_rdata, dmem_wdata, status_flags;
	logic [4:0]  io_addr;
	logic        dmem_re, dmem_we, io_re, ie;
	int          errors = 0;
	int          num_checks = 0;
	logic [31:0] s = 32'hCE34;
	logic [7:0]  a, b, k, v, w, x;
	logic [2:0]  bt;
	logic [6:0]  f1, f2, f3, f4, f5;
	logic [16:0] ws;
	logic [15:0] q [$];

	always #25 clk = ~clk;

	cie_core DUT (.clk, .rst_b, .prog_data, .dmem_rdata, .io_rdata, .irq_enable, .prog_addr,
		.dmem_addr, .dmem_re, .dmem_we, .dmem_wdata, .io_addr, .io_re, .status_flags);
	cie_mem_model mdl (.clk, .prog_addr, .dmem_addr, .dmem_re, .dmem_we, .dmem_wdata,
		.io_addr, .io_re, .prog_data, .dmem_rdata, .io_rdata);

	always @(negedge clk) if (dmem_re === 1'b1) q.push_back(dmem_addr);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction: xs

	function automatic logic [15:0] ldi(input logic [3:0] d, input logic [7:0] kk);
		return {4'hE, kk[7:4], d, kk[3:0]};
	endfunction: ldi

	// Byte add or subtract with carry in: {T,H,S,V,N,Z,C}
	function automatic logic [6:0] fl(input logic [7:0] p, input logic [7:0] m,
		input logic c, input logic sb);
		logic [8:0] r;
		logic [4:0] h;
		logic       ov;
		r = sb ? {1'b0, p} - m - c : {1'b0, p} + m + c;
		h = sb ? {1'b0, p[3:0]} - m[3:0] - c : {1'b0, p[3:0]} + m[3:0] + c;
		ov = (p[7] ^ m[7] ^ ~sb) & (p[7] ^ r[7]);
		return {1'b0, h[4], r[7] ^ ov, ov, r[7], r[7:0] == 8'h00, r[8]};
	endfunction: fl

	// Edges from fetch address f until fetch address t appears
	task automatic span(input logic [15:0] f, input logic [15:0] t, input int n);
		int c;
		c = 0;
		while (prog_addr !== f || DUT.ex !== 1'b1) @(negedge clk);
		while ((prog_addr !== t || DUT.ex !== 1'b1) && c < 50) begin
			@(negedge clk);
			c++;
		end
		`CHK(c, n)
		$display("span %h to %h done", f, t);
	endtask: span

	task automatic conclude();
		$display("checks %0d, mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask: conclude

	initial begin
		repeat (1000) @(posedge clk);
		errors++;
		conclude();
	end

	// ----------------------------------------------------------------
	// Program image and run
	// ----------------------------------------------------------------
	initial begin
		a = 8'(xs());
		b = 8'(xs());
		k = 8'(xs());
		v = 8'(xs());
		w = 8'(xs());
		x = 8'(xs());
		bt = 3'(xs());
		ie = 1'(xs());
		mdl.pm[0] = ldi(4'h0, a);
		mdl.pm[1] = ldi(4'h1, b);
		mdl.pm[2] = 16'h1F01;
		mdl.pm[3] = {4'h4, k[7:4], 4'h0, k[3:0]};
		mdl.pm[4] = 16'h2711;
		mdl.pm[5] = 16'h1312;
		mdl.pm[6] = 16'h9000;
		mdl.pm[9] = ldi(4'hE, 8'h40);
		mdl.pm[10] = ldi(4'hF, 8'h00);
		mdl.pm[11] = 16'h9509;
		mdl.pm[8'h41] = 16'hF018;
		mdl.pm[8'h46] = 16'hF01F;
		mdl.pm[8'h4B] = ldi(4'hA, 8'h80);
		mdl.pm[8'h4C] = ldi(4'hB, 8'h00);
		mdl.pm[8'h4D] = 16'h914D;
		mdl.pm[8'h4E] = 16'h915E;
		mdl.pm[8'h4F] = 16'h3040;
		mdl.pm[8'h50] = 16'h1345;
		mdl.pm[8'h53] = ldi(4'h8, w);
		mdl.pm[8'h54] = ldi(4'h9, 8'hFF);
		mdl.pm[8'h55] = {8'h96, k[5:4], 2'b00, k[3:0]};
		mdl.pm[8'h56] = {13'h1365, bt};
		mdl.dm[8'h80] = v;
		mdl.dm[8'h81] = ~v;
		mdl.io[5] = x;
		f1 = fl(a, b, 1'b0, 1'b0);
		f2 = fl(a + b, k, f1[0], 1'b1);
		f3 = (f2 & 7'h21) | 7'h02;
		f4 = fl(v, 8'h00, 1'b0, 1'b1);
		ws = {9'h0FF, w} + k[5:0];
		f5 = {1'b0, f4[5], ws[15], 1'b0, ws[15], ws[15:0] == 16'h0000, ws[16]};
		@(negedge clk) irq_enable = ie;
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		span(16'h2, 16'h3, 1);
		`CHK(status_flags[6:0], f1)
		span(16'h3, 16'h4, 1);
		`CHK(status_flags[6:0], f2)
		span(16'h4, 16'h5, 1);
		`CHK(status_flags[6:0], f3)
		span(16'h5, 16'h8, 3);
		`CHK(status_flags[6:0], f3)
		span(16'hB, 16'h41, 4);
		`CHK({mdl.dm[8'hDF], mdl.dm[8'hDE]}, 16'h0C00)
		span(16'h41, 16'h46, f3[0] ? 3 : 5);
		span(16'h46, 16'h4B, ie ? 3 : 5);
		span(16'h4D, 16'h4F, 4);
		`CHK({q[0], q[1]}, 32'h00800080)
		span(16'h4F, 16'h50, 1);
		`CHK(status_flags[6:0], f4)
		span(16'h50, 16'h53, 3);
		span(16'h55, 16'h56, 2);
		`CHK(status_flags[6:0], f5)
		span(16'h56, 16'h59, x[bt] ? 3 : 4);
		conclude();
	end
endmodule: test_cpu_instruction_executor
`default_nettype wire
